// File: src/rscl_params.svh
// Purpose: Constants for the reset strap configuration latch
// Assumes: Straps are sampled from host data pins and the clock mode pin
// Notes:   Strap vector layout is fixed here and decoded only in rscl_top
`ifndef RSCL_PARAMS_SVH
`define RSCL_PARAMS_SVH

// Strap vector layout
`define RSCL_STRAP_W        6
`define RSCL_BIT_LANE       0
`define RSCL_BIT_ENDIAN     1
`define RSCL_BIT_BOOT_LO    2
`define RSCL_BIT_BOOT_HI    3
`define RSCL_BIT_HPEN       4
`define RSCL_BIT_CLKSRC     5

// Host data pin positions of the straps
`define RSCL_HD_LANE        12
`define RSCL_HD_ENDIAN      8
`define RSCL_HD_BOOT_LO     3
`define RSCL_HD_BOOT_HI     4
`define RSCL_HD_HPEN        14

// Reset defaults of the latched values
`define RSCL_DEF_LANE       1'h1
`define RSCL_DEF_ENDIAN     1'h1
`define RSCL_DEF_BOOT       2'h1
`define RSCL_DEF_HPEN       1'h1
`define RSCL_DEF_CLKSRC     1'h1

// Boot strap codes
`define RSCL_BOOT_HOST      2'h0
`define RSCL_BOOT_ROM8      2'h1
`define RSCL_BOOT_ROM16     2'h2
`define RSCL_BOOT_ROM32     2'h3

// Shared general I/O pins handed over when the host port is off
`define RSCL_GIO_SHARED     16'hFF0B
`define RSCL_GIO_NONE       16'h0000

`endif

// File: src/rscl_pkg.sv
// Purpose: Types for the reset strap configuration latch
// Assumes: Used through rscl_pkg:: only
// Notes:   Codes are written out in binary
package rscl_pkg;

  // Capture sequencer
  typedef enum logic {
    RSCL_ST_WAIT   = 1'b0,
    RSCL_ST_LOCKED = 1'b1
  } rscl_state_t;

  // Chip select one data width
  typedef enum logic [1:0] {
    RSCL_CS1_W8  = 2'b00,
    RSCL_CS1_W16 = 2'b01,
    RSCL_CS1_W32 = 2'b10
  } rscl_cs1_width_t;

endpackage : rscl_pkg

// File: src/rscl_strap_if.sv
// Purpose: Carries raw strap levels to the synchroniser and back
// Assumes: One clock domain on the core side
// Notes:   Width follows the strap vector
`timescale 1ns/1ps
`include "rscl_params.svh"

interface rscl_strap_if;
  logic [`RSCL_STRAP_W-1:0] pins;
  logic [`RSCL_STRAP_W-1:0] value;
  logic                     stable;

  modport sync (input pins, output value, output stable);
  modport core (output pins, input value, input stable);
endinterface : rscl_strap_if

// File: src/rscl_sync.sv
// Purpose: Three stage synchroniser bank for the strap pins
// Assumes: Pins are asynchronous to ref_clk_i
// Notes:   No reset on the chain so it samples while reset is held
`timescale 1ns/1ps
`include "rscl_params.svh"

module rscl_sync (
  input  wire logic  ref_clk_i,
  rscl_strap_if.sync strap
);

  logic [`RSCL_STRAP_W-1:0] s1_reg;
  logic [`RSCL_STRAP_W-1:0] s2_reg;
  logic [`RSCL_STRAP_W-1:0] s3_reg;

  ////////////////////////////////////////////////////////////////////////
  // Chain keeps running through reset so the pre-release levels arrive
  always_ff @(posedge ref_clk_i) begin
    s1_reg <= strap.pins;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  // A level counts once the second and third stage agree
  assign strap.value  = s3_reg;
  assign strap.stable = (s2_reg == s3_reg);

endmodule : rscl_sync

// File: src/rscl_top.sv
// Purpose: Latch device configuration straps at reset release
// Assumes: Reset held at least three clock edges with straps steady
// Notes:   Latched values stay fixed until the next reset
`timescale 1ns/1ps
`include "rscl_params.svh"

module rscl_top #(
  parameter bit HAS_LANE_OPT = 1'b1
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] host_data_pins_i,
  input  wire logic        clk_src_strap_i,
  input  wire logic [15:0] gen_io_enable_bits_i,
  input  wire logic [15:0] gen_io_direction_bits_i,
  output logic             straps_locked_o,
  output logic             mem_byte_lane_sel_o,
  output logic             endian_sel_o,
  output logic             narrow_on_high_lane_o,
  output logic             host_boot_o,
  output rscl_pkg::rscl_cs1_width_t cs1_width_o,
  output logic             clk_src_sel_o,
  output logic             clk_src_reserved_o,
  output logic             clk_src_changed_o,
  output logic             host_port_en_o,
  output logic             audio_port_b_en_o,
  output logic [15:0]      gen_io_out_en_o,
  output logic [15:0]      gen_io_in_en_o
);

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Width of chip select one for a boot code
  function automatic rscl_pkg::rscl_cs1_width_t boot_width(input logic [1:0] code);
    boot_width = (code == `RSCL_BOOT_ROM8)  ? rscl_pkg::RSCL_CS1_W8 :
                 (code == `RSCL_BOOT_ROM16) ? rscl_pkg::RSCL_CS1_W16 :
                                              rscl_pkg::RSCL_CS1_W32;
  endfunction : boot_width

  // Narrow data goes high only with lane strap high and big endian
  function automatic logic high_lane(input logic lane, input logic little);
    high_lane = lane & ~little;
  endfunction : high_lane

  ////////////////////////////////////////////////////////////////////////
  // Strap gathering and synchronisation

  rscl_strap_if strap ();

  logic                     lane_pin;
  logic [`RSCL_STRAP_W-1:0] raw_straps;

  // Base revision has no lane option and reads as its pull-up
  assign lane_pin = HAS_LANE_OPT ? host_data_pins_i[`RSCL_HD_LANE] : `RSCL_DEF_LANE;

  assign raw_straps = {clk_src_strap_i,
                       host_data_pins_i[`RSCL_HD_HPEN],
                       host_data_pins_i[`RSCL_HD_BOOT_HI],
                       host_data_pins_i[`RSCL_HD_BOOT_LO],
                       host_data_pins_i[`RSCL_HD_ENDIAN],
                       lane_pin};
  assign strap.pins = raw_straps;

  rscl_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .strap     (strap)
  );

  ////////////////////////////////////////////////////////////////////////
  // Capture sequencer

  rscl_pkg::rscl_state_t state_reg;
  rscl_pkg::rscl_state_t state_next;
  logic                  capture;

  // Capture on the first agreeing sample after release
  assign capture    = (state_reg == rscl_pkg::RSCL_ST_WAIT) && strap.stable;
  assign state_next = capture ? rscl_pkg::RSCL_ST_LOCKED : state_reg;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= rscl_pkg::RSCL_ST_WAIT;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next values decoded from the synchronised straps

  logic       lane_v;
  logic       little_v;
  logic [1:0] boot_v;
  logic       hpen_v;
  logic       clksrc_v;

  assign lane_v   = strap.value[`RSCL_BIT_LANE];
  assign little_v = strap.value[`RSCL_BIT_ENDIAN];
  assign boot_v   = strap.value[`RSCL_BIT_BOOT_HI:`RSCL_BIT_BOOT_LO];
  assign hpen_v   = strap.value[`RSCL_BIT_HPEN];
  assign clksrc_v = strap.value[`RSCL_BIT_CLKSRC];

  ////////////////////////////////////////////////////////////////////////
  // Latched configuration, loaded once per reset

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_byte_lane_sel_o   <= `RSCL_DEF_LANE;
      narrow_on_high_lane_o <= high_lane(`RSCL_DEF_LANE, `RSCL_DEF_ENDIAN);
    end else if (capture) begin
      mem_byte_lane_sel_o   <= lane_v;
      narrow_on_high_lane_o <= high_lane(lane_v, little_v);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      endian_sel_o <= `RSCL_DEF_ENDIAN;
      host_boot_o  <= 1'h0;
      cs1_width_o  <= boot_width(`RSCL_DEF_BOOT);
    end else if (capture) begin
      endian_sel_o <= little_v;
      host_boot_o  <= (boot_v == `RSCL_BOOT_HOST);
      cs1_width_o  <= boot_width(boot_v);
    end
  end

  // clock source and reserved code flag
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_src_sel_o      <= `RSCL_DEF_CLKSRC;
      clk_src_reserved_o <= 1'h0;
    end else if (capture) begin
      clk_src_sel_o      <= clksrc_v;
      clk_src_reserved_o <= ~clksrc_v;
    end
  end

  // pin owner, from the strap only
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      host_port_en_o    <= `RSCL_DEF_HPEN;
      audio_port_b_en_o <= ~`RSCL_DEF_HPEN;
    end else if (capture) begin
      host_port_en_o    <= hpen_v;
      audio_port_b_en_o <= ~hpen_v;
    end
  end

  // Locked flag mirrors the sequencer state
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      straps_locked_o <= 1'h0;
    end else begin
      straps_locked_o <= (state_next == rscl_pkg::RSCL_ST_LOCKED);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock source pin watch after lock

  logic clk_mismatch;

  assign clk_mismatch = (state_reg == rscl_pkg::RSCL_ST_LOCKED) && strap.stable &&
                        (clksrc_v != clk_src_sel_o);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_src_changed_o <= 1'h0;
    end else begin
      clk_src_changed_o <= clk_mismatch;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared general I/O gating

  logic [15:0] gio_mask;
  logic [15:0] gio_out_next;
  logic [15:0] gio_in_next;

  assign gio_mask     = audio_port_b_en_o ? `RSCL_GIO_SHARED : `RSCL_GIO_NONE;
  assign gio_out_next = gio_mask & gen_io_enable_bits_i & gen_io_direction_bits_i;
  assign gio_in_next  = gio_mask & gen_io_enable_bits_i & ~gen_io_direction_bits_i;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gen_io_out_en_o <= `RSCL_GIO_NONE;
      gen_io_in_en_o  <= `RSCL_GIO_NONE;
    end else begin
      gen_io_out_en_o <= gio_out_next;
      gen_io_in_en_o  <= gio_in_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_lane_low_only: assert property (
    straps_locked_o && !mem_byte_lane_sel_o |-> !narrow_on_high_lane_o)
    else $error("narrow data off the low lane with lane strap low");

  a_lane_little_low: assert property (
    straps_locked_o && mem_byte_lane_sel_o && endian_sel_o |-> !narrow_on_high_lane_o)
    else $error("little endian narrow data not on low lane");

  a_lane_big_high: assert property (
    straps_locked_o && mem_byte_lane_sel_o && !endian_sel_o |-> narrow_on_high_lane_o)
    else $error("big endian narrow data not on high lane");

  // Capture stays true while reset holds the sequencer and the release edge
  // escapes disable iff, so capture checks also need rst_i low when sampled
  a_endian_capture: assert property (
    !rst_i && capture |=> endian_sel_o == $past(little_v))
    else $error("endian select differs from strap");

  a_boot_width: assert property (
    !rst_i && capture |=> cs1_width_o == boot_width($past(boot_v)) &&
                          host_boot_o == ($past(boot_v) == `RSCL_BOOT_HOST))
    else $error("boot width or method wrong");

  a_clk_reserved: assert property (
    straps_locked_o |-> clk_src_reserved_o == !clk_src_sel_o)
    else $error("reserved clock source not flagged");

  a_clk_watch: assert property (
    clk_mismatch |=> clk_src_changed_o)
    else $error("clock source change not reported");

  a_host_capture: assert property (
    !rst_i && capture |=> host_port_en_o == $past(hpen_v) && audio_port_b_en_o == !$past(hpen_v))
    else $error("host port selection differs from strap");

  a_host_excl: assert property (
    host_port_en_o |=> gen_io_out_en_o == `RSCL_GIO_NONE && gen_io_in_en_o == `RSCL_GIO_NONE)
    else $error("shared gpio active while host port owns pins");

  a_gio_gate: assert property (
    audio_port_b_en_o |=> gen_io_out_en_o ==
      ($past(gen_io_enable_bits_i) & $past(gen_io_direction_bits_i) & `RSCL_GIO_SHARED))
    else $error("gpio output enable not gated by software bits");

  a_latch_hold: assert property (
    straps_locked_o |=> straps_locked_o && $stable(host_port_en_o) && $stable(endian_sel_o) &&
                        $stable(cs1_width_o) && $stable(mem_byte_lane_sel_o) && $stable(clk_src_sel_o))
    else $error("latched configuration changed after lock");

  a_pins_ignored: assert property (
    straps_locked_o && $changed(host_data_pins_i) |=> ##2 $stable(host_port_en_o))
    else $error("host port selection followed a later pin change");

  a_gio_in_gate: assert property (
    audio_port_b_en_o |=> gen_io_in_en_o ==
      ($past(gen_io_enable_bits_i) & ~$past(gen_io_direction_bits_i) & `RSCL_GIO_SHARED))
    else $error("gpio input enable not gated by software bits");

  a_clk_clear: assert property (
    !clk_mismatch |=> !clk_src_changed_o)
    else $error("clock source change reported without a mismatch");

  a_lock_follows: assert property (
    !rst_i && capture |=> straps_locked_o && state_reg == rscl_pkg::RSCL_ST_LOCKED)
    else $error("straps not locked after capture");

  a_owner_excl: assert property (
    host_port_en_o != audio_port_b_en_o)
    else $error("host port and audio port disagree on pin ownership");

  c_lock: cover property (!straps_locked_o ##1 straps_locked_o);
  c_big_high: cover property (straps_locked_o && narrow_on_high_lane_o);
  c_host_boot: cover property (straps_locked_o && host_boot_o);
  c_audio_mode: cover property (audio_port_b_en_o && gen_io_out_en_o != `RSCL_GIO_NONE);
  c_clk_moved: cover property (clk_src_changed_o);

endmodule : rscl_top

// File: tb/rscl_board.sv
// Purpose: Board resistor network seen by the strap pins
// Assumes: Strap levels are static settings from the bench
// Notes:   Pins 15, 6, 5 and 2 may be driven by the board at any time
`timescale 1ns/1ps

module rscl_board (
  input  wire logic        lane_i,
  input  wire logic        endian_i,
  input  wire logic [1:0]  boot_i,
  input  wire logic        hpen_i,
  input  wire logic        clk_src_i,
  input  wire logic [3:0]  drive_i,
  output logic      [15:0] host_data_pins_o,
  output logic             clk_src_strap_o
);
  // Internal pull levels of the pins the board leaves alone
  localparam logic [15:0] PULLS = 16'h2A83;

  ////////////////////////////////////////////////////////////////////////////
  // Pin levels
  // straps held
  always_comb begin
    host_data_pins_o     = PULLS;
    host_data_pins_o[12] = lane_i;
    host_data_pins_o[8]  = endian_i;
    host_data_pins_o[4]  = boot_i[1];
    host_data_pins_o[3]  = boot_i[0];
    host_data_pins_o[14] = hpen_i;
    host_data_pins_o[15] = drive_i[3];
    host_data_pins_o[6]  = drive_i[2];
    host_data_pins_o[5]  = drive_i[1];
    host_data_pins_o[2]  = drive_i[0];
  end

  assign clk_src_strap_o = clk_src_i;
endmodule : rscl_board

// File: tb/test_reset_strap_config_latch.sv
// Purpose: Self-checking bench for the strap latch
// Assumes: Straps steady for the whole reset pulse
// Notes:   Every strap combination class is captured once
`timescale 1ns/1ps
`include "rscl_params.svh"

module test_reset_strap_config_latch;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic lane = 1'b1, endian = 1'b1, hpen = 1'b1, clk_src = 1'b1;
  logic [1:0] boot = 2'h1;
  logic [3:0] drv = 4'h0;
  logic [15:0] gio_en = 16'h0000, gio_dir = 16'h0000, pins, gout, gin;
  logic clk_pin, locked, lane_o, endian_o, high_o, hboot, clks, clkres, clkchg, hpen_o, aud;
  logic base_lane, base_high;
  rscl_pkg::rscl_cs1_width_t cs1;
  int failures = 0;
  int num_checks = 0;

  // Clock
  always #25 ref_clk_i = ~ref_clk_i;

  rscl_board i_rscl_board (.lane_i(lane), .endian_i(endian), .boot_i(boot), .hpen_i(hpen),
    .clk_src_i(clk_src), .drive_i(drv), .host_data_pins_o(pins), .clk_src_strap_o(clk_pin));

  rscl_top #(.HAS_LANE_OPT(1'b1)) i_rscl_top (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .host_data_pins_i(pins), .clk_src_strap_i(clk_pin), .gen_io_enable_bits_i(gio_en),
    .gen_io_direction_bits_i(gio_dir), .straps_locked_o(locked), .mem_byte_lane_sel_o(lane_o),
    .endian_sel_o(endian_o), .narrow_on_high_lane_o(high_o), .host_boot_o(hboot),
    .cs1_width_o(cs1), .clk_src_sel_o(clks), .clk_src_reserved_o(clkres),
    .clk_src_changed_o(clkchg), .host_port_en_o(hpen_o), .audio_port_b_en_o(aud),
    .gen_io_out_en_o(gout), .gen_io_in_en_o(gin));

  // Base revision: lane strap ignored, reads as its pull-up
  rscl_top #(.HAS_LANE_OPT(1'b0)) i_rscl_top_base (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .host_data_pins_i(pins), .clk_src_strap_i(clk_pin), .gen_io_enable_bits_i(gio_en),
    .gen_io_direction_bits_i(gio_dir), .straps_locked_o(), .mem_byte_lane_sel_o(base_lane),
    .endian_sel_o(), .narrow_on_high_lane_o(base_high), .host_boot_o(), .cs1_width_o(),
    .clk_src_sel_o(), .clk_src_reserved_o(), .clk_src_changed_o(), .host_port_en_o(),
    .audio_port_b_en_o(), .gen_io_out_en_o(), .gen_io_in_en_o());

  ////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic check_vec(logic [15:0] got, logic [15:0] exp, string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_vec

  task automatic check_bit(logic got, logic exp, string what);
    check_vec({15'h0000, got}, {15'h0000, exp}, what);
  endtask : check_bit

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // Reset pulse, defaults checked while it is held
  task automatic pulse_reset();
    rst_i <= 1'b1;
    repeat (20) @(posedge ref_clk_i);
    #1;
    check_bit(locked, 1'b0, "locked in reset");
    check_bit(hpen_o, 1'b1, "host port default");
    check_bit(endian_o, 1'b1, "endian default");
    check_vec({14'h0000, cs1}, {14'h0000, rscl_pkg::RSCL_CS1_W8}, "boot default");
    check_bit(clks, 1'b1, "clock source default");
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask : pulse_reset

  // Latched outputs against the captured strap levels
  task automatic check_state(logic l, logic e, logic h, logic c, logic [1:0] b, logic [15:0] d);
    logic [1:0] w;
    w = (b == 2'h1) ? rscl_pkg::RSCL_CS1_W8 : (b == 2'h2) ? rscl_pkg::RSCL_CS1_W16 : rscl_pkg::RSCL_CS1_W32;
    check_bit(locked, 1'b1, "locked");
    check_bit(lane_o, l, "byte lane");
    check_bit(high_o, l & ~e, "high lane");
    check_bit(base_lane, 1'b1, "base revision lane pull-up");
    check_bit(base_high, ~e, "base revision high lane");
    check_bit(endian_o, e, "endian");
    check_bit(hboot, b == 2'h0, "host boot");
    check_vec({14'h0000, cs1}, {14'h0000, w}, "cs1 width");
    check_bit(clks, c, "clock source");
    check_bit(clkres, ~c, "clock reserved");
    check_bit(hpen_o, h, "host port");
    check_bit(aud, ~h, "audio port");
    check_vec(gout, h ? 16'h0000 : `RSCL_GIO_SHARED & d, "gpio out");
    check_vec(gin, h ? 16'h0000 : `RSCL_GIO_SHARED & ~d, "gpio in");
  endtask : check_state

  ////////////////////////////////////////////////////////////////////////////
  // Tests: capture, then disturb every strap and the software direction bits
  initial begin
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk_i);
      lane    <= i[1];
      endian  <= i[0];
      boot    <= i[1:0];
      hpen    <= i[2];
      clk_src <= (i != 5);
      drv     <= i[3:0] ^ 4'hA;
      gio_en  <= 16'hFFFF;
      gio_dir <= 16'h0F0F;
      pulse_reset();
      check_state(i[1], i[0], i[2], i != 5, i[1:0], 16'h0F0F);
      check_bit(clkchg, 1'b0, "clock strap steady");
      @(posedge ref_clk_i);
      lane    <= ~lane;
      endian  <= ~endian;
      boot    <= ~boot;
      hpen    <= ~hpen;
      clk_src <= ~clk_src;
      drv     <= ~drv;
      gio_dir <= 16'hF0F0;
      repeat (8) @(posedge ref_clk_i);
      #1;
      check_state(i[1], i[0], i[2], i != 5, i[1:0], 16'hF0F0);
      check_bit(clkchg, 1'b1, "clock strap moved");
    end
    wrap_up();
  end

  // Watchdog
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    failures++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : test_reset_strap_config_latch
